// >>> pkg/voc_pkg.sv
// package for the video output-control register bank
// assumes a classic wishbone slave with 32-bit data, one word per register
package voc_pkg;
	// printed offsets are not multiples of four: index, byte addr = 4*index
	localparam logic [7:0] OFMT2_IDX   = 8'h29;
	localparam logic [7:0] SWIDTH_IDX  = 8'h2A;
	localparam logic [7:0] ODIS_IDX    = 8'h2B;
	localparam logic [7:0] PWR_IDX     = 8'h2C;
	localparam logic [7:0] MISC_IDX    = 8'h30;
	localparam logic [7:0] STAT_IDX    = 8'h31;
	// reset values
	localparam logic [7:0] OFMT2_RST   = 8'h00;
	localparam logic [7:0] SWIDTH_RST  = 8'h10;
	localparam logic [7:0] ODIS_RST    = 8'hFF;
	localparam logic [7:0] PWR_RST     = 8'h00;
	localparam logic [7:0] MISC_RST    = 8'h00;
	// output_format_two fields
	localparam int CLK_EDGE_BIT  = 0;
	localparam int FIELD_POL_BIT = 1;
	localparam int BLANK_BIT     = 2;
	localparam int SYNC_POL_BIT  = 3;
	localparam int ANCHOR_BIT    = 4;
	localparam int XDIV_BIT      = 5;
	localparam int XEN_BIT       = 6;
	// output_drive_disable fields
	localparam int DIS_SYNC_BIT  = 3;
	localparam int DIS_PCLK_BIT  = 4;
	localparam int DIS_NPCLK_BIT = 5;
	localparam int DIS_DV_BIT    = 6;
	localparam int DIS_FIELD_BIT = 7;
	// misc register: lock edge of input sync, yuv blank levels
	localparam int LOCK_LEAD_BIT = 0;
	localparam int YUV_BIT       = 1;
	// blanking levels
	localparam logic [7:0] BLANK_LUMA   = 8'h00;
	localparam logic [7:0] BLANK_CHROMA = 8'h80;
	localparam logic [31:0] BUS_ZERO    = 32'h0000_0000;
endpackage

// >>> src/voc_sync_gen.sv
// aligned line sync pulse generator, counts pixel-clock cycles
// assumes pix_en_i marks one pixel per clk_i cycle when high
module voc_sync_gen
	import voc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       pix_en_i,
	input  wire logic       anchor_i,
	input  wire logic       lock_lead_i,
	input  wire logic [7:0] width_i,
	input  wire logic       sync_s_i,
	output logic            pulse_o
);
	logic       sync_d_r;
	logic       sync_d_nxt;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [7:0] wid_r;
	logic [7:0] wid_nxt;
	logic       pulse_nxt;
	logic       lock_ev;
	logic       lead_ev;

	// lead event: start of input pulse (input sync taken active high)
	always_comb begin
		lead_ev    = sync_s_i & ~sync_d_r;
		lock_ev    = lock_lead_i ? lead_ev : (~sync_s_i & sync_d_r);
		sync_d_nxt = sync_s_i;
		cnt_nxt    = cnt_r;
		wid_nxt    = wid_r;
		pulse_nxt  = pulse_o;
		if (pix_en_i && cnt_r != 8'h00) begin
			cnt_nxt = cnt_r - 8'h01; // width in pixel cycles
			if (cnt_r == 8'h01) begin
				pulse_nxt = anchor_i ? 1'b0 : 1'b0;
			end
		end
		if (lock_ev) begin
			wid_nxt = width_i; // new width latched per line
			if (!anchor_i) begin
				// leading edge on lock edge, trailing after width
				pulse_nxt = (width_i != 8'h00);
				cnt_nxt   = width_i;
			end else begin
				// trailing edge on lock edge
				pulse_nxt = 1'b0;
				cnt_nxt   = 8'h00;
			end
		end else if (anchor_i && lead_ev && wid_r != 8'h00) begin
			// limitation: leading edge is the input's lead edge, so the
			// pulse cannot start earlier than the input pulse itself
			pulse_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_d_r <= 1'b0;
			cnt_r    <= 8'h00;
			wid_r    <= SWIDTH_RST;
			pulse_o  <= 1'b0;
		end else begin
			sync_d_r <= sync_d_nxt;
			cnt_r    <= cnt_nxt;
			wid_r    <= wid_nxt;
			pulse_o  <= pulse_nxt;
		end
	end

	lead_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(lock_ev && !anchor_i && width_i != 8'h00) |=> pulse_o)
		else $error("sync pulse did not start at lock edge");
	trail_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(lock_ev && anchor_i) |=> !pulse_o)
		else $error("sync pulse did not end at lock edge");
endmodule

// >>> src/voc_output_ctrl.sv
// output-control register bank with wishbone slave and output stage
// assumes pixel data and syncs arrive synchronous to clk_i except pins
module voc_output_ctrl
	import voc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone classic slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// sample path, same clock
	input  wire logic        pix_en_i,
	input  wire logic [7:0]  red_i,
	input  wire logic [7:0]  green_i,
	input  wire logic [7:0]  blue_i,
	input  wire logic        data_valid_i,
	input  wire logic        field_even_i,
	input  wire logic        protect_det_i,
	input  wire logic        raw_line_sync_i,
	input  wire logic        raw_frame_sync_i,
	// pins from outside the clock domain
	input  wire logic        line_sync_input_i,
	input  wire logic        crystal_clk_i,
	// pixel outputs with enables (high = driving)
	output logic [7:0]       red_o,
	output logic [7:0]       green_o,
	output logic [7:0]       blue_o,
	output logic [2:0]       color_oe_o,
	output logic             data_valid_out_o,
	output logic             data_valid_oe_o,
	output logic             field_out_o,
	output logic             field_oe_o,
	output logic             aligned_line_sync_out_o,
	output logic             raw_line_sync_out_o,
	output logic             raw_frame_sync_out_o,
	output logic             sync_oe_o,
	output logic             pixel_clock_out_o,
	output logic             pixel_clock_oe_o,
	output logic             inverted_pixel_clock_out_o,
	output logic             inverted_pixel_clock_oe_o,
	output logic             crystal_clock_out_o,
	// power-down controls
	output logic [2:0]       adc_power_down_o,
	output logic             pll_power_down_o,
	// data launch edge select for the output pad flops
	output logic             launch_rising_o
);
	logic [7:0]  ofmt_r;
	logic [7:0]  ofmt_nxt;
	logic [7:0]  width_r;
	logic [7:0]  width_nxt;
	logic [7:0]  odis_r;
	logic [7:0]  odis_nxt;
	logic [7:0]  pwr_r;
	logic [7:0]  pwr_nxt;
	logic [7:0]  misc_r;
	logic [7:0]  misc_nxt;
	logic        ack_nxt;
	logic [31:0] dat_nxt;
	logic        hit;
	logic        wr_lane;
	logic        sync_s1_r;
	logic        sync_s2_r;

	// word index from byte address; low two bits ignored
	function automatic logic [7:0] reg_index(input logic [9:0] a);
		reg_index = a[9:2];
	endfunction

	// bus decode and register writes; single-cycle ack, then ack drops
	always_comb begin
		hit       = cyc_i & stb_i & ~ack_o;
		wr_lane   = hit & we_i & sel_i[0];
		ofmt_nxt  = ofmt_r;
		width_nxt = width_r;
		odis_nxt  = odis_r;
		pwr_nxt   = pwr_r;
		misc_nxt  = misc_r;
		ack_nxt   = hit;
		dat_nxt   = BUS_ZERO;
		if (wr_lane) begin
			case (reg_index(adr_i))
				OFMT2_IDX:  ofmt_nxt  = {1'b0, dat_i[6:0]};
				SWIDTH_IDX: width_nxt = dat_i[7:0];
				ODIS_IDX:   odis_nxt  = dat_i[7:0];
				PWR_IDX:    pwr_nxt   = {4'h0, dat_i[3:0]};
				MISC_IDX:   misc_nxt  = {6'h00, dat_i[1:0]};
				default:    ;
			endcase
		end
		if (hit && !we_i) begin
			// reads only return state; unmapped reads give zero
			case (reg_index(adr_i))
				OFMT2_IDX:  dat_nxt = {24'h000000, ofmt_r};
				SWIDTH_IDX: dat_nxt = {24'h000000, width_r};
				ODIS_IDX:   dat_nxt = {24'h000000, odis_r};
				PWR_IDX:    dat_nxt = {24'h000000, pwr_r};
				MISC_IDX:   dat_nxt = {24'h000000, misc_r};
				STAT_IDX:   dat_nxt = {30'h0, sync_s2_r, protect_det_i};
				default:    dat_nxt = BUS_ZERO;
			endcase
		end
	end

	// register state; reset values match the power-up state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ofmt_r  <= OFMT2_RST;
			width_r <= SWIDTH_RST;
			odis_r  <= ODIS_RST;
			pwr_r   <= PWR_RST;
			misc_r  <= MISC_RST;
			ack_o   <= 1'b0;
			dat_o   <= BUS_ZERO;
		end else begin
			ofmt_r  <= ofmt_nxt;
			width_r <= width_nxt;
			odis_r  <= odis_nxt;
			pwr_r   <= pwr_nxt;
			misc_r  <= misc_nxt;
			ack_o   <= ack_nxt;
			dat_o   <= dat_nxt;
		end
	end

	// pin synchronisers: the first stage feeds only the second
	logic xtal_s1_r;
	logic xtal_s2_r;
	logic xtal_d_r;
	logic xdiv_r;
	logic xdiv_nxt;
	logic xtal_rise;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_s1_r <= 1'b0;
			sync_s2_r <= 1'b0;
			xtal_s1_r <= 1'b0;
			xtal_s2_r <= 1'b0;
			xtal_d_r  <= 1'b0;
			xdiv_r    <= 1'b0;
		end else begin
			sync_s1_r <= line_sync_input_i;
			sync_s2_r <= sync_s1_r;
			xtal_s1_r <= crystal_clk_i;
			xtal_s2_r <= xtal_s1_r;
			xtal_d_r  <= xtal_s2_r;
			xdiv_r    <= xdiv_nxt;
		end
	end

	// crystal divide-by-two toggles on each sampled rising edge
	// limitation: sampled crystal must be well below half of clk_i
	always_comb begin
		xtal_rise = xtal_s2_r & ~xtal_d_r;
		xdiv_nxt  = xtal_rise ? ~xdiv_r : xdiv_r;
	end

	// aligned sync pulse generator
	logic pulse;
	voc_sync_gen u_sync (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.pix_en_i    (pix_en_i),
		.anchor_i    (ofmt_r[ANCHOR_BIT]),
		.lock_lead_i (misc_r[LOCK_LEAD_BIT]),
		.width_i     (width_r),
		.sync_s_i    (sync_s2_r),
		.pulse_o     (pulse)
	);

	// output data stage: blanking, field, syncs registered
	logic       blank;
	logic [7:0] chroma_blank;
	always_comb begin
		blank        = ofmt_r[BLANK_BIT] & protect_det_i;
		chroma_blank = misc_r[YUV_BIT] ? BLANK_CHROMA : BLANK_LUMA;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			red_o                   <= 8'h00;
			green_o                 <= 8'h00;
			blue_o                  <= 8'h00;
			data_valid_out_o        <= 1'b0;
			field_out_o             <= 1'b0;
			aligned_line_sync_out_o <= 1'b0;
			raw_line_sync_out_o     <= 1'b0;
			raw_frame_sync_out_o    <= 1'b0;
			crystal_clock_out_o     <= 1'b0;
		end else begin
			// yuv: luma on green, chroma on red and blue
			red_o   <= blank ? chroma_blank : red_i;
			green_o <= blank ? BLANK_LUMA : green_i;
			blue_o  <= blank ? chroma_blank : blue_i;
			data_valid_out_o <= data_valid_i;
			// odd = low by default
			field_out_o <= field_even_i ^ ofmt_r[FIELD_POL_BIT];
			aligned_line_sync_out_o <= pulse ^ ofmt_r[SYNC_POL_BIT];
			raw_line_sync_out_o  <= raw_line_sync_i;
			raw_frame_sync_out_o <= raw_frame_sync_i;
			if (!ofmt_r[XEN_BIT]) begin
				crystal_clock_out_o <= 1'b0;
			end else begin
				crystal_clock_out_o <= ofmt_r[XDIV_BIT] ? xdiv_r : xtal_s2_r;
			end
		end
	end

	// drive enables and pixel clock; pixel clock pads are combinational
	always_comb begin
		color_oe_o                 = ~odis_r[2:0];
		sync_oe_o                  = ~odis_r[DIS_SYNC_BIT];
		pixel_clock_oe_o           = ~odis_r[DIS_PCLK_BIT];
		inverted_pixel_clock_oe_o  = ~odis_r[DIS_NPCLK_BIT];
		data_valid_oe_o            = ~odis_r[DIS_DV_BIT];
		field_oe_o                 = ~odis_r[DIS_FIELD_BIT];
		pixel_clock_out_o          = pix_en_i;
		inverted_pixel_clock_out_o = ~pix_en_i;
		launch_rising_o            = ofmt_r[CLK_EDGE_BIT];
		adc_power_down_o           = pwr_r[2:0];
		pll_power_down_o           = pwr_r[3];
	end

	blank_levels_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ofmt_r[BLANK_BIT] && protect_det_i) |=> (green_o == 8'h00))
		else $error("blanked luma not zero");
	sync_pol_a: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> aligned_line_sync_out_o ==
		($past(pulse) ^ $past(ofmt_r[SYNC_POL_BIT])))
		else $error("aligned sync polarity wrong");
	field_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!field_even_i && !ofmt_r[FIELD_POL_BIT]) |=> !field_out_o)
		else $error("odd field not low");
	xtal_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ofmt_r[XEN_BIT] |=> !crystal_clock_out_o)
		else $error("crystal output not held low");
	drive_dis_a: assert property (@(posedge clk_i) disable iff (rst_i)
		odis_r[DIS_SYNC_BIT] |-> !sync_oe_o && !color_oe_o[0] == odis_r[0]
		)
		else $error("drive enable mismatch");
	reset_dis_a: assert property (@(posedge clk_i)
		$past(rst_i) |-> odis_r == 8'hFF)
		else $error("disable register not 0xFF after reset");
	power_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pll_power_down_o == pwr_r[3] && adc_power_down_o == pwr_r[2:0])
		else $error("power-down mapping wrong");
	read_back_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(hit && !we_i && reg_index(adr_i) == SWIDTH_IDX)
		|=> ack_o && dat_o[7:0] == $past(width_r))
		else $error("width readback wrong");
endmodule

// >>> sim/voc_video_sink.sv
// downstream video processor model: resolves pins, counts sync cycles
// assumes the bench tells it the programmed aligned sync polarity
module voc_video_sink (
	input  wire logic        clk_i,
	input  wire logic        sync_i,
	input  wire logic        sync_oe_i,
	input  wire logic        pol_i,
	input  wire logic [7:0]  red_i,
	input  wire logic        red_oe_i,
	output logic [7:0]       red_w_o,
	output logic [31:0]      active_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// a released bus floats; no pull on these pins
	assign red_w_o = red_oe_i ? red_i : 8'hZZ;
	initial active_o = 32'h0;
	// counts cycles the driven sync sits at its active level
	always @(posedge clk_i) begin
		if (sync_oe_i && sync_i === ~pol_i)
			active_o <= active_o + 32'h1;
	end
endmodule

// >>> sim/voc_output_ctrl_test.sv
// self-checking bench for the output-control register bank
// assumes a 100 MHz clock, sync reset and the sink model beside the block
module voc_output_ctrl_test;
	import voc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0, rst_i = 1'b1;
	logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [9:0]  adr_i = 10'h0;
	logic [3:0]  sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, dat_o, act, q;
	logic        ack_o, pix_en_i = 1'b1, data_valid_i = 1'b0;
	logic [7:0]  red_i = 8'h0, green_i = 8'h0, blue_i = 8'h0;
	logic [7:0]  red_o, green_o, blue_o, red_w;
	logic        field_even_i = 1'b0, protect_det_i = 1'b0, pol = 1'b0;
	logic        raw_line_sync_i = 1'b0, raw_frame_sync_i = 1'b0;
	logic        line_sync_input_i = 1'b0, crystal_clk_i = 1'b0;
	logic [2:0]  color_oe_o, adc_power_down_o;
	logic        data_valid_oe_o, field_out_o, field_oe_o, sync_oe_o;
	logic        aligned_line_sync_out_o, pixel_clock_oe_o, pll_power_down_o;
	logic        inverted_pixel_clock_oe_o, crystal_clock_out_o;
	logic        launch_rising_o;
	int          error_cnt = 0, checks_done = 0, seed = 93101, xc = 0;

	always #5 clk_i = ~clk_i;
	// crystal pin toggles every third cycle, period of six clocks
	always @(posedge clk_i) begin
		xc <= (xc == 2) ? 0 : xc + 1;
		if (xc == 2)
			crystal_clk_i <= ~crystal_clk_i;
	end
	// background levels keep the pass-through paths moving
	always @(posedge clk_i) begin
		data_valid_i     <= 1'($random(seed));
		raw_line_sync_i  <= 1'($random(seed));
		raw_frame_sync_i <= 1'($random(seed));
	end

	voc_output_ctrl voc_output_ctrl_i (.clk_i, .rst_i, .cyc_i, .stb_i,
		.we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .pix_en_i, .red_i,
		.green_i, .blue_i, .data_valid_i, .field_even_i, .protect_det_i,
		.raw_line_sync_i, .raw_frame_sync_i, .line_sync_input_i,
		.crystal_clk_i, .red_o, .green_o, .blue_o, .color_oe_o,
		.data_valid_out_o(), .data_valid_oe_o, .field_out_o, .field_oe_o,
		.aligned_line_sync_out_o, .raw_line_sync_out_o(),
		.raw_frame_sync_out_o(), .sync_oe_o, .pixel_clock_out_o(),
		.pixel_clock_oe_o, .inverted_pixel_clock_out_o(),
		.inverted_pixel_clock_oe_o, .crystal_clock_out_o,
		.adc_power_down_o, .pll_power_down_o, .launch_rising_o);
	voc_video_sink voc_video_sink_i (.clk_i,
		.sync_i(aligned_line_sync_out_o), .sync_oe_i(sync_oe_o),
		.pol_i(pol), .red_i(red_o), .red_oe_i(color_oe_o[0]),
		.red_w_o(red_w), .active_o(act));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] idx,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= {idx, 2'h0};
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 40);
		if (n >= 40) begin
			error_cnt++;
			test_done();
		end
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		wb(1'b0, idx, 32'h0);
		chk(q, {24'h0, exp});
	endtask
	// unused high bits of narrow registers read back as zero
	function automatic logic [7:0] msk(input logic [7:0] idx);
		return idx == OFMT2_IDX ? 8'h7F : idx == PWR_IDX ? 8'h0F : 8'hFF;
	endfunction
	function automatic logic [23:0] pix_exp(input logic [2:0] c,
		input logic [23:0] d);
		if (!(c[0] && !c[2]))
			return d;
		return c[1] ? {BLANK_CHROMA, BLANK_LUMA, BLANK_CHROMA} : 24'h0;
	endfunction

	// watchdog: the whole run needs well under ten thousand cycles
	initial begin
		#200000;
		error_cnt++;
		test_done();
	end

	initial begin
		logic [7:0]  ids [4];
		logic [7:0]  rsv [4];
		logic [7:0]  v;
		logic [31:0] d;
		int          c, r [3];
		ids = '{OFMT2_IDX, SWIDTH_IDX, ODIS_IDX, PWR_IDX};
		rsv = '{OFMT2_RST, SWIDTH_RST, ODIS_RST, PWR_RST};
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({pixel_clock_oe_o, inverted_pixel_clock_oe_o, data_valid_oe_o,
			field_oe_o, sync_oe_o, color_oe_o}, 32'h0);
		for (c = 0; c < 4; c++)
			rdchk(ids[c], rsv[c]);
		rdchk(8'h3F, 8'h0);
		for (c = 0; c < 12; c++) begin
			d = $random(seed);
			wb(1'b1, ids[c % 4], d);
			rdchk(ids[c % 4], d[7:0] & msk(ids[c % 4]));
		end
		// corner values first, then random enable and power patterns
		for (c = 0; c < 6; c++) begin
			v = (c == 0) ? 8'h00 : (c == 1) ? 8'hFF : 8'($random(seed));
			wb(1'b1, ODIS_IDX, {24'h0, v});
			wb(1'b1, PWR_IDX, {24'h0, v});
			wb(1'b1, OFMT2_IDX, {24'h0, v});
			chk({field_oe_o, data_valid_oe_o, inverted_pixel_clock_oe_o,
				pixel_clock_oe_o, sync_oe_o, color_oe_o},
				{24'h0, 8'(~v)});
			chk(red_w === 8'hZZ, v[0]);
			chk({pll_power_down_o, adc_power_down_o}, v[3:0]);
			chk(launch_rising_o, v[0]);
		end
		wb(1'b1, ODIS_IDX, 32'h0);
		for (c = 0; c < 8; c++) begin
			v = $random(seed);
			wb(1'b1, OFMT2_IDX, {30'h0, v[1], 1'h0});
			field_even_i <= v[0];
			repeat (2) @(posedge clk_i);
			chk(field_out_o, v[0] ^ v[1]);
		end
		// every blank, yuv and detect combination
		for (c = 0; c < 8; c++) begin
			d = $random(seed);
			wb(1'b1, MISC_IDX, {30'h0, c[1], 1'h0});
			wb(1'b1, OFMT2_IDX, {29'h0, c[0], 2'h0});
			protect_det_i <= ~c[2];
			{red_i, green_i, blue_i} <= d[23:0];
			repeat (2) @(posedge clk_i);
			chk({red_o, green_o, blue_o}, pix_exp(c[2:0], d[23:0]));
		end
		protect_det_i <= 1'b0;
		for (c = 0; c < 3; c++) begin
			wb(1'b1, OFMT2_IDX, (c == 0) ? 32'h0 : (c == 1) ? 32'h40 : 32'h60);
			r[c] = 0;
			v[0] = crystal_clock_out_o;
			repeat (240) begin
				@(posedge clk_i);
				r[c] += (crystal_clock_out_o && !v[0]);
				v[0] = crystal_clock_out_o;
			end
		end
		chk(r[0], 32'h0);
		chk(r[1] >= 38 && r[1] <= 42, 1'h1);
		chk(r[2] >= 18 && r[2] <= 22, 1'h1);
		// one line each: polarity, lock edge and width corners
		for (c = 0; c < 5; c++) begin
			v = (c == 4) ? 8'($random(seed)) : (c == 3) ? 8'hFF : 8'(c);
			wb(1'b1, SWIDTH_IDX, {24'h0, v});
			wb(1'b1, MISC_IDX, {31'h0, c[1]});
			wb(1'b1, OFMT2_IDX, {28'h0, c[0], 3'h0});
			pol <= c[0];
			repeat (40) @(posedge clk_i);
			d = act;
			line_sync_input_i <= 1'b1;
			repeat (20) @(posedge clk_i);
			line_sync_input_i <= 1'b0;
			repeat (300) @(posedge clk_i);
			chk(act - d, {24'h0, v});
		end
		test_done();
	end
endmodule
